// file: hdl/rsw_pkg.sv
// Constants, register map and state types of the reset supervisor and watchdog
package rsw_pkg;

    // Clock and machine cycle
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MC_OSC_PERIODS = 12;
    localparam logic [3:0] MC_DIV_LAST = 4'(MC_OSC_PERIODS - 1);

    // Low-supply release delay
    localparam int unsigned LVR_HOLD_MS = 10;
    localparam int unsigned LVR_HOLD_CYCLES = LVR_HOLD_MS * (CLK_HZ / 1000);

    // Watchdog reset pulse: oscillator periods times a power of two
    localparam int unsigned WDOG_RST_MULT = 12;
    localparam int unsigned WDOG_RST_EXP = 15;
    localparam int unsigned WDOG_RST_CYCLES = WDOG_RST_MULT * (32'h1 << WDOG_RST_EXP);

    // Watchdog counter
    localparam logic [21:0] WDOG_FULL = 22'h3FFFFF;
    localparam logic [21:0] WDOG_CNT_RESET = 22'h000000;
    localparam logic [14:0] WDOG_LOW_CLEAR = 15'h0000;
    localparam logic [6:0] WDOG_RELOAD_MAX = 7'h7E;
    localparam logic [7:0] WDOG_KEY_OFF = 8'h55;
    localparam logic [7:0] WDOG_KEY_RESET = 8'h00;

    // USB bus-reset detection: consecutive single-ended-zero samples
    localparam logic [3:0] USB_SE0_COUNT = 4'h4;

    // Register indices; byte address is four times the index
    localparam int unsigned ADDR_WIDTH = 10;
    localparam logic [7:0] IDX_WDOG_RELOAD = 8'hA6;
    localparam logic [7:0] IDX_WDOG_KEY = 8'hAE;
    localparam logic [7:0] IDX_POWER_CONTROL = 8'hB0;
    localparam logic [7:0] IDX_USB_INT_STATUS = 8'hB1;
    localparam logic [7:0] IDX_USB_INT_ENABLE = 8'hB2;

    // Field positions
    localparam int unsigned PCTL_LVR_DIS_BIT = 5;
    localparam int unsigned USB_INTERRUPT_ENABLE_RST_CPU_BIT = 6;
    localparam int unsigned USB_INTERRUPT_STATUS_RST_FLAG_BIT = 0;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_WIDTH-1:0] address;
        logic [31:0] writedata;
    } rsw_avs_req_t;

    // Whole state of the top module
    typedef struct packed {
        logic wait_r;
        logic [31:0] rdata_r;
        logic [3:0] mc_cnt_r;
        logic mc_tick_r;
        logic [21:0] wd_cnt_r;
        logic wd_fire_r;
        logic [7:0] key_r;
        logic lvr_dis_r;
        logic usb_cpu_en_r;
        logic [3:0] se0_cnt_r;
        logic usb_det_r;
        logic usb_flag_r;
        logic int_rst_r;
        logic logic_rst_n_r;
    } rsw_state_t;

    // Whole state of a reset stretcher
    typedef struct packed {
        logic [31:0] cnt_r;
        logic hold_r;
    } rsw_stretch_state_t;

endpackage

// file: hdl/rsw_stretch.sv
// Reset stretcher: holds its output for a fixed count after the trigger ends
`timescale 1ns/1ps
module rsw_stretch
    import rsw_pkg::*;
#(
    parameter int unsigned CYCLES = 16
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic trig_i,
    output logic hold_o
);

    rsw_stretch_state_t s;
    rsw_stretch_state_t n;

    always_comb begin
        n = s;
        n.hold_r = trig_i || (s.cnt_r != 32'h0);
        if (trig_i) begin
            n.cnt_r = 32'(CYCLES - 1);
        end else if (s.cnt_r != 32'h0) begin
            n.cnt_r = s.cnt_r - 32'h1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign hold_o = s.hold_r;

    default clocking st_cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    stretch_start_a: assert property (trig_i |=> s.hold_r && s.cnt_r == 32'(CYCLES - 1))
        else $error("stretcher did not start on trigger");
    stretch_end_a: assert property ((!trig_i && s.cnt_r == 32'h1) ##1 !trig_i |=> !s.hold_r)
        else $error("stretcher held past its count");

endmodule

// file: hdl/rsw_sync.sv
// Two-flop synchroniser for asynchronous reset sources
`timescale 1ns/1ps
module rsw_sync
    import rsw_pkg::*;
#(
    parameter int unsigned WIDTH = 3
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta_r;
        logic [WIDTH-1:0] sync_r;
    } rsw_sync_state_t;

    rsw_sync_state_t s;
    rsw_sync_state_t n;

    // First stage feeds only the second stage
    always_comb begin
        n = s;
        n.meta_r = async_i;
        n.sync_r = s.meta_r;
    end

    // Zero at reset: an active-low pin then reads as asserted until sampled
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign sync_o = s.sync_r;

endmodule

// file: hdl/rsw_top.sv
// Reset supervisor and watchdog with Avalon-MM register slave
`timescale 1ns/1ps
module rsw_top
    import rsw_pkg::*;
#(
    parameter logic [21:0] WDOG_FULL_P = WDOG_FULL,
    parameter int unsigned LVR_HOLD_P = LVR_HOLD_CYCLES,
    parameter int unsigned WDOG_RST_P = WDOG_RST_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire rsw_avs_req_t avs_req_i,
    output logic avs_waitrequest_o,
    output logic [31:0] avs_readdata_o,
    input wire logic ext_reset_n_i,
    input wire logic low_supply_i,
    input wire logic usb_se0_i,
    output logic internal_reset_o,
    output logic logic_reset_n_o,
    output logic usb_bus_reset_flag_o
);

    rsw_state_t s;
    rsw_state_t n;

    logic [2:0] src_sync;
    logic ext_reset_n_s;
    logic low_supply_s;
    logic usb_se0_s;
    logic lvr_hold;
    logic wd_hold;
    logic lvr_trig;
    logic usb_rst;
    logic any_rst;
    logic wd_en;
    logic bus_take;
    logic wr_take;
    logic [7:0] idx;
    logic reload_ok;
    logic [31:0] rd_mux;

    // Pins and the analog detector come from outside the clock domain
    rsw_sync #(
        .WIDTH(3)
    ) u_sync (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .async_i({usb_se0_i, low_supply_i, ext_reset_n_i}),
        .sync_o(src_sync)
    );

    assign ext_reset_n_s = src_sync[0];
    assign low_supply_s = src_sync[1];
    assign usb_se0_s = src_sync[2];

    // Low-supply source, gated by the disable bit, released 10ms late
    // No mode input gates this path, so it keeps working in Idle and Power-down
    assign lvr_trig = low_supply_s && !s.lvr_dis_r;

    rsw_stretch #(
        .CYCLES(LVR_HOLD_P)
    ) u_lvr_stretch (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .trig_i(lvr_trig),
        .hold_o(lvr_hold)
    );

    // Watchdog overflow pulse stretched to the documented reset width
    rsw_stretch #(
        .CYCLES(WDOG_RST_P)
    ) u_wd_stretch (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .trig_i(s.wd_fire_r),
        .hold_o(wd_hold)
    );

    assign usb_rst = s.usb_det_r && s.usb_cpu_en_r;
    assign any_rst = !ext_reset_n_s || lvr_hold || wd_hold || usb_rst;
    assign wd_en = (s.key_r != WDOG_KEY_OFF);

    // A request is taken at the edge where waitrequest is low
    assign bus_take = (avs_req_i.read || avs_req_i.write) && !s.wait_r;
    assign wr_take = bus_take && avs_req_i.write;
    assign idx = avs_req_i.address[ADDR_WIDTH-1:2];
    // 7F lies outside the service range and is ignored
    assign reload_ok = wr_take && (idx == IDX_WDOG_RELOAD)
        && (avs_req_i.writedata[6:0] <= WDOG_RELOAD_MAX);

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (idx)
            IDX_WDOG_RELOAD: begin
                rd_mux = {25'h0, s.wd_cnt_r[21:15]};
            end
            IDX_WDOG_KEY: begin
                rd_mux = {24'h000000, s.key_r};
            end
            IDX_POWER_CONTROL: begin
                rd_mux[PCTL_LVR_DIS_BIT] = s.lvr_dis_r;
            end
            IDX_USB_INT_STATUS: begin
                rd_mux[USB_INTERRUPT_STATUS_RST_FLAG_BIT] = s.usb_flag_r;
            end
            IDX_USB_INT_ENABLE: begin
                rd_mux[USB_INTERRUPT_ENABLE_RST_CPU_BIT] = s.usb_cpu_en_r;
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    always_comb begin
        n = s;

        // Machine-cycle enable: one pulse per twelve oscillator periods
        n.mc_tick_r = 1'b0;
        if (s.mc_cnt_r == MC_DIV_LAST) begin
            n.mc_cnt_r = 4'h0;
            n.mc_tick_r = 1'b1;
        end else begin
            n.mc_cnt_r = s.mc_cnt_r + 4'h1;
        end

        // One wait cycle per access, then release for a cycle
        n.wait_r = 1'b1;
        if ((avs_req_i.read || avs_req_i.write) && s.wait_r) begin
            n.wait_r = 1'b0;
            n.rdata_r = rd_mux;
        end

        // Watchdog counter; nothing gates it on Idle, only the key does
        n.wd_fire_r = 1'b0;
        if (s.int_rst_r) begin
            n.wd_cnt_r = WDOG_CNT_RESET;
        end else if (reload_ok) begin
            n.wd_cnt_r = {avs_req_i.writedata[6:0], WDOG_LOW_CLEAR};
        end else if (s.mc_tick_r && wd_en) begin
            if (s.wd_cnt_r == WDOG_FULL_P) begin
                n.wd_cnt_r = WDOG_CNT_RESET;
                n.wd_fire_r = 1'b1;
            end else begin
                n.wd_cnt_r = s.wd_cnt_r + 22'h000001;
            end
        end

        // Key and power control return to defaults on any internal reset
        if (s.int_rst_r) begin
            n.key_r = WDOG_KEY_RESET;
            n.lvr_dis_r = 1'b0;
        end else begin
            if (wr_take && idx == IDX_WDOG_KEY) begin
                n.key_r = avs_req_i.writedata[7:0];
            end
            if (wr_take && idx == IDX_POWER_CONTROL) begin
                n.lvr_dis_r = avs_req_i.writedata[PCTL_LVR_DIS_BIT];
            end
        end

        // Kept through internal reset so a held bus reset keeps the CPU held
        if (wr_take && idx == IDX_USB_INT_ENABLE) begin
            n.usb_cpu_en_r = avs_req_i.writedata[USB_INTERRUPT_ENABLE_RST_CPU_BIT];
        end

        // Count consecutive single-ended-zero samples, one per machine cycle
        if (!usb_se0_s) begin
            n.se0_cnt_r = 4'h0;
        end else if (s.mc_tick_r && s.se0_cnt_r != USB_SE0_COUNT) begin
            n.se0_cnt_r = s.se0_cnt_r + 4'h1;
        end
        n.usb_det_r = usb_se0_s && (s.se0_cnt_r == USB_SE0_COUNT);

        // Write one to clear; a detection in the same cycle wins
        if (wr_take && idx == IDX_USB_INT_STATUS
            && avs_req_i.writedata[USB_INTERRUPT_STATUS_RST_FLAG_BIT]) begin
            n.usb_flag_r = 1'b0;
        end
        if (s.usb_det_r) begin
            n.usb_flag_r = 1'b1;
        end

        // Both reset outputs come from flops of the same cause
        n.int_rst_r = any_rst;
        n.logic_rst_n_r = !any_rst;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.wait_r <= 1'b1;
            s.wd_cnt_r <= WDOG_CNT_RESET;
            s.key_r <= WDOG_KEY_RESET;
            s.int_rst_r <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign avs_waitrequest_o = s.wait_r;
    assign avs_readdata_o = s.rdata_r;
    assign internal_reset_o = s.int_rst_r;
    assign logic_reset_n_o = s.logic_rst_n_r;
    assign usb_bus_reset_flag_o = s.usb_flag_r;

    default clocking top_cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    rst_assert_a: assert property (any_rst |=> internal_reset_o && !logic_reset_n_o)
        else $error("internal reset missed an active source");
    rst_release_a: assert property (!any_rst |=> !internal_reset_o && logic_reset_n_o)
        else $error("internal reset held with no source active");
    rst_polarity_a: assert property (logic_reset_n_o == !internal_reset_o)
        else $error("logic module reset not inverse of internal reset");
    wd_advance_a: assert property (s.mc_tick_r && wd_en && !reload_ok && !s.int_rst_r
        && s.wd_cnt_r != WDOG_FULL_P |=> s.wd_cnt_r == $past(s.wd_cnt_r) + 22'h000001)
        else $error("watchdog did not advance on a machine cycle");
    wd_idle_a: assert property (!s.mc_tick_r && !reload_ok && !s.int_rst_r
        |=> $stable(s.wd_cnt_r))
        else $error("watchdog moved between machine cycles");
    wd_overflow_a: assert property (s.mc_tick_r && wd_en && !reload_ok && !s.int_rst_r
        && s.wd_cnt_r == WDOG_FULL_P |=> s.wd_fire_r ##2 internal_reset_o)
        else $error("watchdog overflow gave no reset");
    wd_reload_a: assert property (reload_ok && !s.int_rst_r
        |=> s.wd_cnt_r == {$past(avs_req_i.writedata[6:0]), WDOG_LOW_CLEAR})
        else $error("reload value not placed in the top counter bits");
    wd_key_a: assert property (s.key_r == WDOG_KEY_OFF && !reload_ok && !s.int_rst_r
        |=> $stable(s.wd_cnt_r) && !s.wd_fire_r)
        else $error("watchdog ran while the key disabled it");
    mc_tick_a: assert property (s.mc_tick_r |=> !s.mc_tick_r [*8])
        else $error("machine cycle enable came too early");
    usb_flag_a: assert property (s.usb_det_r |=> usb_bus_reset_flag_o)
        else $error("bus reset detection did not set the flag");
    usb_reset_a: assert property (usb_rst |=> internal_reset_o)
        else $error("enabled USB bus reset did not reset the CPU");
    usb_count_a: assert property (!usb_se0_s
        |=> s.se0_cnt_r == 4'h0 && !s.usb_det_r)
        else $error("bus reset count survived a gap in single-ended zero");
    usb_clear_a: assert property (wr_take && idx == IDX_USB_INT_STATUS
        && avs_req_i.writedata[USB_INTERRUPT_STATUS_RST_FLAG_BIT] && !s.usb_det_r
        |=> !usb_bus_reset_flag_o)
        else $error("bus reset flag not cleared by a write of one");

    // Defaults forced during the combined reset, register writes landing outside it, low-supply gating and the watchdog reset pulse
    wd_clear_a: assert property (internal_reset_o |=> s.wd_cnt_r == WDOG_CNT_RESET)
        else $error("watchdog counter not cleared by internal reset");
    key_default_a: assert property (internal_reset_o
        |=> s.key_r == WDOG_KEY_RESET && !s.lvr_dis_r)
        else $error("key or disable bit not back to default after reset");
    key_write_a: assert property (wr_take && idx == IDX_WDOG_KEY && !internal_reset_o
        |=> s.key_r == $past(avs_req_i.writedata[7:0]))
        else $error("key write did not land");
    lvr_write_a: assert property (wr_take && idx == IDX_POWER_CONTROL && !internal_reset_o
        |=> s.lvr_dis_r == $past(avs_req_i.writedata[PCTL_LVR_DIS_BIT]))
        else $error("power control write did not land");
    lvr_gate_a: assert property (low_supply_s && !s.lvr_dis_r |=> lvr_hold)
        else $error("enabled low-supply source did not start its hold");
    reload_ignore_a: assert property (wr_take && idx == IDX_WDOG_RELOAD
        && avs_req_i.writedata[6:0] > WDOG_RELOAD_MAX && !s.mc_tick_r && !internal_reset_o
        |=> $stable(s.wd_cnt_r))
        else $error("out-of-range reload value changed the counter");
    wd_fire_once_a: assert property (s.wd_fire_r |=> !s.wd_fire_r)
        else $error("watchdog overflow pulse longer than one cycle");
    wd_hold_a: assert property (wd_hold |=> internal_reset_o)
        else $error("watchdog reset hold not seen on internal reset");

    // Register slave handshake: one wait cycle, then a single low cycle
    bus_wait_a: assert property ((avs_req_i.read || avs_req_i.write) && avs_waitrequest_o
        |=> !avs_waitrequest_o)
        else $error("request not answered after one wait cycle");
    bus_release_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    bus_idle_a: assert property (!(avs_req_i.read || avs_req_i.write)
        |=> avs_waitrequest_o)
        else $error("waitrequest fell with no request");
    bus_rdata_a: assert property (avs_req_i.read && avs_waitrequest_o
        |=> avs_readdata_o == $past(rd_mux))
        else $error("read data not loaded for the answered read");
    rd_upper_a: assert property (avs_readdata_o[31:8] == 24'h000000)
        else $error("upper read data bits not zero");

endmodule

// file: testbench/reset_supervisor_watchdog_bench.sv
// Self-checking bench for the reset supervisor and watchdog
`timescale 1ns/1ps
module reset_supervisor_watchdog_bench
    import rsw_pkg::*;
;
    // Short counts keep the run small; expectations derive from these
    localparam logic [21:0] WF_P = 22'h00000F;
    localparam int WD_TICKS = 16;
    localparam int LH = 20;
    localparam int WR = 16;
    localparam int PIN_LOW = 10000;
    logic clk;
    logic rst;
    rsw_avs_req_t req;
    logic waitreq;
    logic [31:0] rdata;
    logic ext_reset_n;
    logic low_supply;
    logic usb_se0;
    logic int_rst;
    logic logic_rst_n;
    logic usb_flag;
    int failures = 0;
    int samples_checked = 0;
    int seed = 32'h91A0;
    int n;
    int i;
    logic [6:0] v;
    logic [7:0] k;

    rsw_top #(.WDOG_FULL_P(WF_P), .LVR_HOLD_P(LH), .WDOG_RST_P(WR)) rsw_top_i (
        .clock_i(clk), .rst_i(rst), .avs_req_i(req), .avs_waitrequest_o(waitreq),
        .avs_readdata_o(rdata), .ext_reset_n_i(ext_reset_n), .low_supply_i(low_supply),
        .usb_se0_i(usb_se0), .internal_reset_o(int_rst), .logic_reset_n_o(logic_rst_n),
        .usb_bus_reset_flag_o(usb_flag)
    );

    function automatic int wd_expect();
        return WD_TICKS * MC_OSC_PERIODS;
    endfunction

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic cycles(input int c);
        repeat (c) @(posedge clk);
    endtask

    // Holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic rd, input logic [7:0] idx, input logic [31:0] wd,
            output logic [31:0] rd_o);
        int j;
        @(posedge clk);
        req <= '{read: rd, write: !rd, address: {idx, 2'b00}, writedata: wd};
        for (j = 0; j < 40; j++) begin
            @(posedge clk);
            if (waitreq === 1'b0) break;
        end
        rd_o = rdata;
        req <= '0;
        if (j == 40) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, j, 0);
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b0, idx, wd, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b1, idx, 32'h0, d);
        check(d, exp);
    endtask

    // Counts cycles until the combined reset reaches val; also checks the inverted copy
    task automatic wait_rst(input logic val, input int lim, output int cnt);
        cnt = 0;
        while (int_rst !== val) begin
            @(posedge clk);
            cnt++;
            if (cnt > lim) begin
                failures++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, int_rst, val);
                end_of_test();
            end
        end
        check(logic_rst_n, !val);
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        req = '0;
        ext_reset_n = 1'b0;
        low_supply = 1'b0;
        usb_se0 = 1'b0;
        cycles(16);
        rst <= 1'b0;
        cycles(PIN_LOW);
        check(int_rst, 1'b1);
        check(logic_rst_n, 1'b0);
        ext_reset_n <= 1'b1;
        wait_rst(1'b0, 8, n);
        chk_rng(n, 1, 5);
        $display("test power_up done");

        wr(IDX_WDOG_RELOAD, 32'h0);
        wait_rst(1'b1, 400, n);
        chk_rng(n, wd_expect() - 14, wd_expect() + 14);
        wait_rst(1'b0, 40, n);
        chk_rng(n, WR - 2, WR + 4);
        rdchk(IDX_WDOG_KEY, 32'h0);
        $display("test watchdog_expiry done");

        wr(IDX_WDOG_RELOAD, 32'h0);
        wr(IDX_WDOG_KEY, 32'h55);
        cycles(wd_expect() + 60);
        check(int_rst, 1'b0);
        rdchk(IDX_WDOG_KEY, 32'h55);
        k = 8'($random(seed));
        while (k == 8'h55) k = 8'($random(seed));
        wr(IDX_WDOG_KEY, {24'h0, k});
        rdchk(IDX_WDOG_KEY, {24'h0, k});
        wait_rst(1'b1, wd_expect() + 40, n);
        wait_rst(1'b0, 40, n);
        $display("test watchdog_key done");

        for (i = 0; i < 4; i++) begin
            v = (i == 0) ? 7'h7E : 7'(($random(seed) & 32'h7FFFFFFF) % 126 + 1);
            wr(IDX_WDOG_RELOAD, {25'h0, v});
            rdchk(IDX_WDOG_RELOAD, {25'h0, v});
            wr(IDX_WDOG_RELOAD, 32'h7F);
            rdchk(IDX_WDOG_RELOAD, {25'h0, v});
        end
        wr(IDX_WDOG_RELOAD, 32'h0);
        rdchk(IDX_WDOG_RELOAD, 32'h0);
        wr(8'h10, 32'hFF);
        rdchk(8'h10, 32'h0);
        $display("test reload_map done");

        rdchk(IDX_POWER_CONTROL, 32'h0);
        low_supply <= 1'b1;
        wait_rst(1'b1, 8, n);
        chk_rng(n, 1, 6);
        cycles(30);
        low_supply <= 1'b0;
        wait_rst(1'b0, LH + 10, n);
        chk_rng(n, LH, LH + 6);
        wr(IDX_WDOG_RELOAD, 32'h0);
        wr(IDX_POWER_CONTROL, 32'h20);
        rdchk(IDX_POWER_CONTROL, 32'h20);
        low_supply <= 1'b1;
        cycles(12);
        check(int_rst, 1'b0);
        low_supply <= 1'b0;
        cycles(4);
        wr(IDX_POWER_CONTROL, 32'h0);
        $display("test low_supply done");

        wr(IDX_WDOG_RELOAD, 32'h0);
        wr(IDX_USB_INT_ENABLE, 32'h0);
        usb_se0 <= 1'b1;
        cycles(2 * MC_OSC_PERIODS);
        check(usb_flag, 1'b0);
        cycles(4 * MC_OSC_PERIODS);
        check(usb_flag, 1'b1);
        check(int_rst, 1'b0);
        usb_se0 <= 1'b0;
        cycles(2);
        rdchk(IDX_USB_INT_STATUS, 32'h1);
        wr(IDX_USB_INT_STATUS, 32'h1);
        rdchk(IDX_USB_INT_STATUS, 32'h0);
        check(usb_flag, 1'b0);
        wr(IDX_USB_INT_ENABLE, 32'h40);
        rdchk(IDX_USB_INT_ENABLE, 32'h40);
        usb_se0 <= 1'b1;
        wait_rst(1'b1, 8 * MC_OSC_PERIODS, n);
        cycles(20);
        check(int_rst, 1'b1);
        usb_se0 <= 1'b0;
        wait_rst(1'b0, 2 * MC_OSC_PERIODS + 8, n);
        wr(IDX_USB_INT_ENABLE, 32'h0);
        $display("test usb_reset done");

        // Service well inside the timeout for several times its length
        for (i = 0; i < 5; i++) begin
            cycles(wd_expect() / 2);
            wr(IDX_WDOG_RELOAD, 32'h0);
        end
        check(int_rst, 1'b0);
        $display("test periodic_service done");

        ext_reset_n <= 1'b0;
        wait_rst(1'b1, 8, n);
        chk_rng(n, 2, 5);
        ext_reset_n <= 1'b1;
        wait_rst(1'b0, 8, n);
        chk_rng(n, 2, 5);
        $display("test pin_reset done");
        end_of_test();
    end
endmodule
